// file: rtl/ptr_cfg.svh
// Constants of the pressure and temperature readout block.
// Assumes a 100 MHz core clock; included by bare name where needed.
`ifndef PTR_CFG_SVH
`define PTR_CFG_SVH

// Bus addressing and command bytes
`define PTR_ADDR7        7'h78
`define PTR_CMD_MEAS     8'hAC
`define PTR_CMD_CFG_WR   8'h54
`define PTR_CMD_CFG_RD   8'h14
`define PTR_CMD_NORMAL   8'hA8
`define PTR_CMD_CMDMODE  8'hA9

// Oversampling word fields and power-on content
`define PTR_PRESSURE_OVERSAMPLING_HI     13
`define PTR_PRESSURE_OVERSAMPLING_LO     11
`define PTR_TEMPERATURE_OVERSAMPLING_HI     15
`define PTR_TEMPERATURE_OVERSAMPLING_LO     14
`define PTR_CFG_INIT     16'h0000
`define PTR_CFG_CRC      8'h81
`define PTR_CRC_POLY     8'h31
`define PTR_CRC_SEED     8'hFF

// Result read length and last byte index
`define PTR_RES_BYTES    6
`define PTR_LAST_IDX     3'h5

// Timing, each in its own unit
`define PTR_CLK_NS       10
`define PTR_MS_NS        1000000
`define PTR_T_COMM_US    1000
`define PTR_T_START_US   2500
`define PTR_T_WAKE_US    500

// Typical pressure conversion times per code, in ms
`define PTR_TP_128X      203
`define PTR_TP_64X       105
`define PTR_TP_32X       56
`define PTR_TP_16X       31
`define PTR_TP_8X        19
`define PTR_TP_4X        13
`define PTR_TP_2X        10
// Temperature conversion time per code, in ms; included in the above
`define PTR_TT_MS        0

`endif

// file: rtl/ptr_pkg.sv
// Types shared by the readout block.
// Assumes nothing of its surroundings.
package ptr_pkg;

	// Bus side sequencer states
	typedef enum logic [3:0] {
		L_IDLE, L_ADDR, L_ACK_A, L_CMD, L_ACK_C,
		L_DATA, L_ACK_D, L_DROP, L_READ, L_RACK
	} ptr_link_t;

	// Measurement sequencer states
	typedef enum logic [2:0] {
		S_POR, S_CHECK, S_IDLE, S_WAKE, S_MEAS, S_SLEEP
	} ptr_meas_t;

	// Status byte as seen by the host
	typedef struct packed {
		logic       rsvd7;
		logic       power;
		logic       busy;
		logic       rsvd4;
		logic       cmd_mode;
		logic       crc_fail;
		logic [1:0] rsvd10;
	} ptr_status_t;

	// One calibrated result pair
	typedef struct packed {
		logic [23:0] pressure;
		logic [23:0] temperature;
	} ptr_result_t;

endpackage

// file: rtl/ptr_sync.sv
// Two-stage level synchroniser, any width.
// Assumes each bit changes at most once per two destination edges.
`timescale 1ns/1ps
module ptr_sync #(
	parameter int W = 1
) (
	input  wire logic         i_clk,   // Destination clock
	input  wire logic         i_rst_b, // Sync reset, active low
	input  wire logic [W-1:0] i_d,     // Foreign level
	output logic      [W-1:0] o_q      // Synchronised level
);
	logic [W-1:0] meta;

	// First stage feeds only the second
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			meta <= '0;
			o_q  <= '0;
		end else begin
			meta <= i_d;
			o_q  <= meta;
		end
	end
endmodule // ptr_sync

// file: rtl/ptr_crc8.sv
// Checksum over the 16-bit oversampling word, high byte first.
// Purely combinational; the caller registers the verdict.
`timescale 1ns/1ps
`include "ptr_cfg.svh"
module ptr_crc8 (
	input  wire logic [15:0] i_data, // Word to check
	output logic      [7:0]  o_crc   // Resulting checksum
);
	// Bitwise shift-register form, one bit per step
	always_comb begin
		logic [7:0] c;
		c = `PTR_CRC_SEED;
		for (int b = 15; b >= 0; b--) begin
			if (c[7] ^ i_data[b]) begin
				c = {c[6:0], 1'b0} ^ `PTR_CRC_POLY;
			end else begin
				c = {c[6:0], 1'b0};
			end
		end
		o_crc = c;
	end
endmodule // ptr_crc8

// file: rtl/ptr_readout.sv
// Measurement trigger and result readout of the sensor, I2C target.
// Assumes SCL is a clock port that only runs during frames and that
// SDA and SCL are open drain with pull-ups outside.
`timescale 1ns/1ps
`include "ptr_cfg.svh"

module ptr_readout #(
	parameter int unsigned CYC_PER_MS   = `PTR_MS_NS / `PTR_CLK_NS,
	parameter int unsigned COMM_CYC     =
		`PTR_T_COMM_US * (`PTR_MS_NS / 1000) / `PTR_CLK_NS,
	parameter int unsigned START_CYC    =
		`PTR_T_START_US * (`PTR_MS_NS / 1000) / `PTR_CLK_NS,
	parameter int unsigned WAKE_CYC     =
		`PTR_T_WAKE_US * (`PTR_MS_NS / 1000) / `PTR_CLK_NS,
	parameter logic [15:0] CFG_INIT     = `PTR_CFG_INIT,
	parameter logic [7:0]  CFG_CRC      = `PTR_CFG_CRC
) (
	input  wire logic        I_CLK,         // Core clock, 100 MHz
	input  wire logic        I_RST_B,       // Reset, active low; sync except at the async start detector
	input  wire logic        I_SCL,         // Bus clock, link domain
	input  wire logic        I_SDA,         // Bus data level
	output logic             O_SDA,         // Bus data drive value
	output logic             O_SDA_OE,      // Bus data pulled low
	input  wire logic [23:0] I_PRESSURE,    // Converted pressure
	input  wire logic [23:0] I_TEMPERATURE, // Converted temperature
	output logic             O_MEASURING,   // Conversion running
	output logic             O_SLEEP        // Sleep standby
);
	// ---------------- Core domain ----------------
	ptr_pkg::ptr_meas_t   mstate;
	ptr_pkg::ptr_result_t result;
	logic [31:0] timer;
	logic        comm_ok;
	logic        crc_fail;
	logic        res_tog;
	logic        pend;
	logic        trig_sync;
	logic        trig_seen;
	logic        trig_evt;
	logic [2:0]  pressure_oversampling;
	logic [1:0]  temperature_oversampling;
	logic [7:0]  crc_calc;
	logic [31:0] meas_cyc;

	// ---------------- Link domain ----------------
	ptr_pkg::ptr_link_t   lstate;
	ptr_pkg::ptr_status_t status;
	ptr_pkg::ptr_result_t res_l;
	logic        link_rst_b;
	logic        start_tog;
	logic        start_seen;
	logic        start_hit;
	logic [7:0]  shreg;
	logic [7:0]  next_byte;
	logic [2:0]  bit_cnt;
	logic [2:0]  byte_idx;
	logic [7:0]  txreg;
	logic [7:0]  next_tx;
	logic        rd_cfg;
	logic        cfg_half;
	logic [15:0] cfg;
	logic        cmd_mode;
	logic        link_busy;
	logic        trig_tog;
	logic        trig_fire;
	logic [1:0]  lvl_sync;
	logic        res_sync;
	logic        res_seen;
	logic        res_new;

	// Pressure conversion time per oversampling code
	function automatic logic [31:0] tp_ms(input logic [2:0] c);
		unique case (c)
			3'h0: tp_ms = 32'(`PTR_TP_128X);
			3'h1: tp_ms = 32'(`PTR_TP_64X);
			3'h2: tp_ms = 32'(`PTR_TP_32X);
			3'h3: tp_ms = 32'(`PTR_TP_16X);
			3'h4: tp_ms = 32'(`PTR_TP_8X);
			3'h5: tp_ms = 32'(`PTR_TP_4X);
			3'h6: tp_ms = 32'(`PTR_TP_2X);
			3'h7: tp_ms = 32'(`PTR_TP_2X);
		endcase
	endfunction

	// Duration is pressure plus temperature conversion time
	assign meas_cyc = (tp_ms(pressure_oversampling) + 32'(`PTR_TT_MS)) *
		CYC_PER_MS;

	// Checksum of the store content present at power-on
	ptr_crc8 u_crc (
		.i_data (CFG_INIT),
		.o_crc  (crc_calc)
	);

	// Trigger toggle from the link side
	ptr_sync #(.W(1)) u_trig_sync (
		.i_clk   (I_CLK),
		.i_rst_b (I_RST_B),
		.i_d     (trig_tog),
		.o_q     (trig_sync)
	);

	assign trig_evt = trig_sync ^ trig_seen;

	// Remember a trigger until a measurement can take it
	always_ff @(posedge I_CLK) begin
		if (!I_RST_B) begin
			trig_seen <= 1'b0;
			pend      <= 1'b0;
			pressure_oversampling     <= 3'h0;
			temperature_oversampling     <= 2'h0;
		end else begin
			trig_seen <= trig_sync;
			if (trig_evt) begin
				pend  <= 1'b1;
				pressure_oversampling <= cfg[`PTR_PRESSURE_OVERSAMPLING_HI:`PTR_PRESSURE_OVERSAMPLING_LO];
				temperature_oversampling <= cfg[`PTR_TEMPERATURE_OVERSAMPLING_HI:`PTR_TEMPERATURE_OVERSAMPLING_LO];
			end else if (mstate == ptr_pkg::S_IDLE ||
				mstate == ptr_pkg::S_SLEEP) begin
				pend <= 1'b0;
			end
		end
	end

	// Power-up, check, wake and conversion sequencing
	always_ff @(posedge I_CLK) begin
		if (!I_RST_B) begin
			mstate   <= ptr_pkg::S_POR;
			timer    <= START_CYC;
			crc_fail <= 1'b0;
			res_tog  <= 1'b0;
			result   <= '0;
		end else begin
			unique case (mstate)
				ptr_pkg::S_POR: begin
					if (timer == 32'h0000_0000) begin
						mstate <= ptr_pkg::S_CHECK;
					end else begin
						timer <= timer - 32'h0000_0001;
					end
				end
				ptr_pkg::S_CHECK: begin
					crc_fail <= (crc_calc != CFG_CRC);
					mstate   <= ptr_pkg::S_IDLE;
				end
				ptr_pkg::S_IDLE, ptr_pkg::S_SLEEP: begin
					// Timer runs down to zero inclusive, so a conversion loads one less; wake loads WAKE_CYC whole
					if (pend && mstate == ptr_pkg::S_IDLE) begin
						mstate <= ptr_pkg::S_MEAS;
						timer  <= meas_cyc - 32'h0000_0001;
					end else if (pend) begin
						mstate <= ptr_pkg::S_WAKE;
						timer  <= WAKE_CYC;
					end
				end
				ptr_pkg::S_WAKE: begin
					if (timer == 32'h0000_0000) begin
						mstate <= ptr_pkg::S_MEAS;
						timer  <= meas_cyc - 32'h0000_0001;
					end else begin
						timer <= timer - 32'h0000_0001;
					end
				end
				ptr_pkg::S_MEAS: begin
					if (timer == 32'h0000_0000) begin
						result.pressure    <= I_PRESSURE;
						result.temperature <= I_TEMPERATURE;
						res_tog <= ~res_tog;
						mstate  <= ptr_pkg::S_SLEEP;
					end else begin
						timer <= timer - 32'h0000_0001;
					end
				end
			endcase
		end
	end

	// Bus access allowed once COMM_CYC cycles of the power-up wait have passed
	always_ff @(posedge I_CLK) begin
		if (!I_RST_B) begin
			comm_ok <= 1'b0;
		end else if (mstate != ptr_pkg::S_POR ||
			timer <= START_CYC - COMM_CYC) begin
			comm_ok <= 1'b1;
		end
	end

	// Status pins of the core side
	always_ff @(posedge I_CLK) begin
		if (!I_RST_B) begin
			O_MEASURING <= 1'b0;
			O_SLEEP     <= 1'b0;
		end else begin
			O_MEASURING <= (mstate == ptr_pkg::S_MEAS);
			O_SLEEP     <= (mstate == ptr_pkg::S_SLEEP);
		end
	end

	// ---------------- Link domain logic ----------------

	// Reset brought onto the bus clock
	ptr_sync #(.W(1)) u_rst_sync (
		.i_clk   (I_SCL),
		.i_rst_b (1'b1),
		.i_d     (I_RST_B),
		.o_q     (link_rst_b)
	);

	// Core levels and result toggle onto the bus clock
	ptr_sync #(.W(2)) u_lvl_sync (
		.i_clk   (I_SCL),
		.i_rst_b (link_rst_b),
		.i_d     ({comm_ok, crc_fail}),
		.o_q     (lvl_sync)
	);

	ptr_sync #(.W(1)) u_res_sync (
		.i_clk   (I_SCL),
		.i_rst_b (link_rst_b),
		.i_d     (res_tog),
		.o_q     (res_sync)
	);

	// Start condition: data falls while the clock is high
	always_ff @(negedge I_SDA or negedge I_RST_B) begin
		if (!I_RST_B) begin
			start_tog <= 1'b0;
		end else if (I_SCL) begin
			start_tog <= ~start_tog;
		end
	end

	assign start_hit = start_tog ^ start_seen;
	assign res_new   = res_sync ^ res_seen;
	assign next_byte = {shreg[6:0], I_SDA};
	assign trig_fire = (lstate == ptr_pkg::L_ACK_C) && !link_busy &&
		(shreg == `PTR_CMD_MEAS);

	// Status byte content
	always_comb begin
		status          = '0;
		status.power    = 1'b1;
		status.busy     = link_busy;
		status.cmd_mode = cmd_mode;
		status.crc_fail = lvl_sync[0];
	end

	// Next byte to send, result or stored word
	always_comb begin
		next_tx = 8'h00;
		unique case (byte_idx + 3'h1)
			3'h1: next_tx = rd_cfg ? cfg[15:8] : res_l.pressure[23:16];
			3'h2: next_tx = rd_cfg ? cfg[7:0] : res_l.pressure[15:8];
			3'h3: next_tx = rd_cfg ? 8'h00 : res_l.pressure[7:0];
			3'h4: next_tx = rd_cfg ? 8'h00 : res_l.temperature[23:16];
			3'h5: next_tx = rd_cfg ? 8'h00 : res_l.temperature[15:8];
			default: next_tx = 8'h00;
		endcase
	end

	// Busy from trigger until the new results arrive
	always_ff @(posedge I_SCL) begin
		if (!link_rst_b) begin
			link_busy <= 1'b0;
			trig_tog  <= 1'b0;
			res_seen  <= 1'b0;
			res_l     <= '0;
		end else begin
			res_seen <= res_sync;
			if (trig_fire) begin
				link_busy <= 1'b1;
				trig_tog  <= ~trig_tog;
			end else if (res_new) begin
				link_busy <= 1'b0;
				res_l     <= result;
			end
		end
	end

	// Bit level sequencer, sampling on the rising clock
	always_ff @(posedge I_SCL) begin
		if (!link_rst_b) begin
			lstate     <= ptr_pkg::L_IDLE;
			start_seen <= 1'b0;
			shreg      <= 8'h00;
			bit_cnt    <= 3'h0;
			byte_idx   <= 3'h0;
			txreg      <= 8'h00;
			rd_cfg     <= 1'b0;
			cfg_half   <= 1'b0;
			cfg        <= CFG_INIT;
			cmd_mode   <= 1'b0;
		end else begin
			start_seen <= start_tog;
			bit_cnt    <= bit_cnt + 3'h1;
			if (start_hit) begin
				lstate  <= ptr_pkg::L_ADDR;
				shreg   <= {7'h00, I_SDA};
				bit_cnt <= 3'h1;
			end else begin
				unique case (lstate)
				ptr_pkg::L_IDLE, ptr_pkg::L_DROP: begin
					bit_cnt <= 3'h0;
				end
				ptr_pkg::L_ADDR: begin
					shreg <= next_byte;
					if (bit_cnt == 3'h7) begin
						lstate <= (next_byte[7:1] == `PTR_ADDR7 &&
							lvl_sync[1]) ? ptr_pkg::L_ACK_A
							: ptr_pkg::L_IDLE;
					end
				end
				ptr_pkg::L_ACK_A: begin
					bit_cnt <= 3'h0;
					if (shreg[0]) begin
						lstate   <= ptr_pkg::L_READ;
						byte_idx <= 3'h0;
						txreg    <= status;
					end else begin
						lstate <= ptr_pkg::L_CMD;
					end
				end
				ptr_pkg::L_CMD, ptr_pkg::L_DATA: begin
					shreg <= next_byte;
					if (bit_cnt == 3'h7) begin
						lstate <= (lstate == ptr_pkg::L_CMD) ?
							ptr_pkg::L_ACK_C : ptr_pkg::L_ACK_D;
					end
				end
				ptr_pkg::L_ACK_C: begin
					bit_cnt <= 3'h0;
					lstate  <= ptr_pkg::L_DROP;
					if (!link_busy) begin
						rd_cfg <= (shreg == `PTR_CMD_CFG_RD);
						if (shreg == `PTR_CMD_CFG_WR) begin
							lstate   <= ptr_pkg::L_DATA;
							cfg_half <= 1'b0;
						end
						if (shreg == `PTR_CMD_CMDMODE) begin
							cmd_mode <= 1'b1;
						end
						if (shreg == `PTR_CMD_NORMAL) begin
							cmd_mode <= 1'b0;
						end
					end
				end
				ptr_pkg::L_ACK_D: begin
					bit_cnt  <= 3'h0;
					cfg_half <= 1'b1;
					if (!cfg_half) begin
						cfg[15:8] <= shreg;
						lstate    <= ptr_pkg::L_DATA;
					end else begin
						cfg[7:0] <= shreg;
						lstate   <= ptr_pkg::L_DROP;
					end
				end
				ptr_pkg::L_READ: begin
					if (bit_cnt == 3'h7) begin
						lstate <= ptr_pkg::L_RACK;
					end
				end
				ptr_pkg::L_RACK: begin
					bit_cnt <= 3'h0;
					if (!I_SDA && byte_idx != `PTR_LAST_IDX) begin
						lstate   <= ptr_pkg::L_READ;
						byte_idx <= byte_idx + 3'h1;
						txreg    <= next_tx;
					end else begin
						lstate <= ptr_pkg::L_IDLE;
					end
				end
				endcase
			end
		end
	end

	// Data drive on the falling clock: acks and read bits
	always_ff @(negedge I_SCL) begin
		if (!link_rst_b) begin
			O_SDA    <= 1'b0;
			O_SDA_OE <= 1'b0;
		end else begin
			O_SDA    <= 1'b0;
			O_SDA_OE <= (lstate == ptr_pkg::L_ACK_A) ||
				(lstate == ptr_pkg::L_ACK_C) ||
				(lstate == ptr_pkg::L_ACK_D) ||
				(lstate == ptr_pkg::L_READ &&
				!txreg[3'h7 - bit_cnt]);
		end
	end
endmodule // ptr_readout

// file: verification/ptr_host_model.sv
// Host controller model: clocks the bus and pulls data low.
// Assumes the bench resolves the open-drain wire.
`timescale 1ns/1ps
module ptr_host_model (
	input  wire logic i_sda,     // Wire level
	output logic      o_scl,     // Bus clock
	output logic      o_sda_low  // Pull data low
);
	// Both lines released at rest, clock still
	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end
	// Clock pulses with data released
	task pulse(input int n);
		repeat (n) begin
			#3 o_scl = 1'b0;
			#3 o_scl = 1'b1;
		end
	endtask
	// Start or repeated start
	task start();
		#1 o_sda_low = 1'b0;
		#2 o_scl = 1'b1;
		#3 o_sda_low = 1'b1;
		#3 o_scl = 1'b0;
	endtask
	// Data changes only while the clock is low
	task wbit(input logic b);
		#1 o_sda_low = !b;
		#2 o_scl = 1'b1;
		#3 o_scl = 1'b0;
	endtask
	// Byte out, high bit first, then the target's answer
	task wbyte(input logic [7:0] d, output logic ack);
		for (int i = 7; i >= 0; i--) wbit(d[i]);
		#1 o_sda_low = 1'b0;
		#2 o_scl = 1'b1;
		ack = !i_sda;
		#3 o_scl = 1'b0;
	endtask
	// Byte in; every byte answered but the last
	task rbyte(input logic last, output logic [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			#3 o_scl = 1'b1;
			d[i] = i_sda;
			#3 o_scl = 1'b0;
		end
		wbit(last);
		#1 o_sda_low = 1'b0;
	endtask
	// Stop: data rises while the clock is high
	task stop();
		#1 o_sda_low = 1'b1;
		#2 o_scl = 1'b1;
		#3 o_sda_low = 1'b0;
		#3;
	endtask
endmodule // ptr_host_model

// file: verification/ptr_readout_monitor.sv
// Port checker of the readout block.
// Assumes the bind hands on the shortened timing parameters.
`timescale 1ns/1ps
module ptr_readout_chk #(
	parameter int unsigned CYC_PER_MS = 10,
	parameter int unsigned COMM_CYC   = 20,
	parameter int unsigned START_CYC  = 40
) (
	input wire logic        I_CLK,         // Core clock
	input wire logic        I_RST_B,       // Reset
	input wire logic        I_SCL,         // Bus clock
	input wire logic        I_SDA,         // Wire level
	input wire logic        O_SDA,         // Drive value
	input wire logic        O_SDA_OE,      // Pull low
	input wire logic [23:0] I_PRESSURE,    // Pressure
	input wire logic [23:0] I_TEMPERATURE, // Temperature
	input wire logic        O_MEASURING,   // Converting
	input wire logic        O_SLEEP        // Standby
);
	logic [31:0] since;
	logic [31:0] meas_cnt;
	logic        oe_rise;
	// Age since reset and length of the running conversion
	always_ff @(posedge I_CLK) begin
		if (!I_RST_B) begin
			since <= 32'h0000_0000;
			meas_cnt <= 32'h0000_0000;
		end else begin
			if (since != 32'hFFFF_FFFF)
				since <= since + 1;
			meas_cnt <= O_MEASURING ? meas_cnt + 1 : 32'h0000_0000;
		end
	end
	// Pull level caught at each bus clock rise
	always_ff @(posedge I_SCL) begin
		oe_rise <= O_SDA_OE;
	end
	AST_SDA_LOW: assert property (@(posedge I_CLK)
		disable iff (!I_RST_B) O_SDA == 1'b0)
		else $error("Data drive value not low");
	AST_NO_EARLY_ACK: assert property (@(posedge I_CLK)
		disable iff (!I_RST_B) O_SDA_OE |-> since >= COMM_CYC)
		else $error("Bus answered too early");
	AST_NO_EARLY_MEAS: assert property (@(posedge I_CLK)
		disable iff (!I_RST_B) O_MEASURING |-> since >= START_CYC)
		else $error("Conversion before power-up wait");
	AST_MEAS_MAX: assert property (@(posedge I_CLK)
		disable iff (!I_RST_B) O_MEASURING |-> meas_cnt < 203 * CYC_PER_MS)
		else $error("Conversion longer than slowest setting");
	AST_MEAS_MIN: assert property (@(posedge I_CLK)
		disable iff (!I_RST_B)
		$fell(O_MEASURING) |-> meas_cnt >= 10 * CYC_PER_MS)
		else $error("Conversion shorter than fastest setting");
	AST_SLEEP_AFTER: assert property (@(posedge I_CLK)
		disable iff (!I_RST_B) $fell(O_MEASURING) |-> ##[0:2] O_SLEEP)
		else $error("No standby after conversion");
	AST_SLEEP_EXCL: assert property (@(posedge I_CLK)
		disable iff (!I_RST_B) O_SLEEP |-> !O_MEASURING)
		else $error("Standby while converting");
	AST_OE_STABLE: assert property (@(negedge I_SCL)
		disable iff (!I_RST_B) O_SDA_OE == oe_rise)
		else $error("Data changed while bus clock high");
	// Main scenarios reached
	cover property (@(posedge I_CLK) $fell(O_MEASURING));
	cover property (@(posedge I_CLK) $rose(O_SDA_OE));
	cover property (@(posedge I_CLK) $rose(O_SLEEP));
endmodule // ptr_readout_chk
bind ptr_readout ptr_readout_chk #(
	.CYC_PER_MS(CYC_PER_MS), .COMM_CYC(COMM_CYC), .START_CYC(START_CYC)
) u_chk (.I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_SCL(I_SCL),
	.I_SDA(I_SDA), .O_SDA(O_SDA), .O_SDA_OE(O_SDA_OE),
	.I_PRESSURE(I_PRESSURE), .I_TEMPERATURE(I_TEMPERATURE),
	.O_MEASURING(O_MEASURING), .O_SLEEP(O_SLEEP));

// file: verification/ptr_readout_tb_top.sv
// Testbench of the readout block against a host model.
// Assumes shortened timing parameters and an open-drain wire.
`timescale 1ns/1ps
module ptr_readout_tb_top;
	localparam int CPM = 10;
	localparam int STRT = 40;
	localparam logic [23:0] PRES = 24'h9B_B0C5;
	localparam logic [23:0] TEMP = 24'h56_AA3C;
	logic        clk, rst_b, scl, sda, h_low;
	logic        o_sda, o_sda_oe, o_measuring, o_sleep;
	logic [23:0] i_pressure, i_temperature;
	logic [47:0] d;
	int          mismatches, tests_run, n;
	int          cyc = 0;
	// Open-drain wire from both parties
	assign sda = !(h_low || (o_sda_oe && !o_sda));
	ptr_readout #(.CYC_PER_MS(CPM), .COMM_CYC(20), .START_CYC(STRT),
		.WAKE_CYC(5)) i_dut (.I_CLK(clk), .I_RST_B(rst_b), .I_SCL(scl),
		.I_SDA(sda), .O_SDA(o_sda), .O_SDA_OE(o_sda_oe),
		.I_PRESSURE(i_pressure), .I_TEMPERATURE(i_temperature),
		.O_MEASURING(o_measuring), .O_SLEEP(o_sleep));
	ptr_host_model i_host (.i_sda(sda), .o_scl(scl), .o_sda_low(h_low));
	always #5 clk = ~clk;
	// Hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 10000) begin
			mismatches++;
			give_verdict();
		end
	end
	task give_verdict();
		$display("Checks %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [47:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Write transfer of k command bytes, top byte first
	task automatic wr(input logic [23:0] b, input int k);
		logic a;
		i_host.start();
		i_host.wbyte(8'hF0, a);
		chk("write address ack", a, 1'b1);
		for (int i = 0; i < k; i++) begin
			i_host.wbyte(b[23 - 8 * i -: 8], a);
			chk("command ack", a, 1'b1);
		end
		i_host.stop();
	endtask
	// Read transfer of k bytes into the low end of d
	task automatic rd(input int k);
		logic a;
		logic [7:0] v;
		d = '0;
		i_host.start();
		i_host.wbyte(8'hF1, a);
		chk("read address ack", a, 1'b1);
		for (int i = 0; i < k; i++) begin
			i_host.rbyte(i == k - 1, v);
			d = {d[39:0], v};
		end
		i_host.stop();
	endtask
	// Length of the next conversion in core cycles
	task automatic meas();
		int w;
		w = 0;
		n = 0;
		while (o_measuring !== 1'b1 && w < 100) begin
			@(negedge clk);
			w++;
		end
		while (o_measuring === 1'b1 && n < 3000) begin
			@(negedge clk);
			n++;
		end
	endtask
	// Address before the bus is ready, then foreign addresses
	task automatic t_addr(input logic early);
		logic       a;
		logic [7:0] adr [3];
		adr = '{8'hF0, 8'hE0, 8'hF2};
		for (int i = 0; i < (early ? 1 : 3); i++) begin
			i_host.start();
			i_host.wbyte(adr[i], a);
			i_host.stop();
			chk("address ack", a, !early && i == 0);
		end
	endtask
	// Measurement with a mode change sent while busy
	task automatic t_meas();
		fork
			meas();
			begin
				wr(24'hAC_0000, 1);
				rd(1);
				chk("busy status", d, 48'h60);
				wr(24'hA9_0000, 1);
			end
		join
		chk("conversion length", n, 203 * CPM);
		repeat (3) @(negedge clk);
		chk("standby", o_sleep, 1'b1);
		i_pressure = ~PRES;
		i_temperature = ~TEMP;
		rd(6);
		chk("result", d, {8'h40, PRES, TEMP[23:8]});
	endtask
	// Mode commands
	task automatic t_mode();
		wr(24'hA9_0000, 1);
		rd(1);
		chk("command mode", d, 48'h48);
		wr(24'hA8_0000, 1);
		rd(1);
		chk("normal mode", d, 48'h40);
	endtask
	// New oversampling word, then a measurement from standby
	task automatic t_cfg();
		wr(24'h54_1800, 3);
		wr(24'h14_0000, 1);
		rd(3);
		chk("config word", d, 48'h40_1800);
		fork
			meas();
			wr(24'hAC_0000, 1);
		join
		chk("short conversion", n, 31 * CPM);
		repeat (3) @(negedge clk);
		rd(6);
		chk("second result", d, {8'h40, ~PRES, ~TEMP[23:8]});
	endtask
	initial begin
		clk = 1'b0;
		rst_b = 1'b1;
		// A real falling edge clears the asynchronous start detector
		#1 rst_b = 1'b0;
		i_pressure = PRES;
		i_temperature = TEMP;
		mismatches = 0;
		tests_run = 0;
		fork
			i_host.pulse(6);
			repeat (8) @(negedge clk);
		join
		rst_b = 1'b1;
		t_addr(1'b1);
		repeat (STRT + 10) @(negedge clk);
		t_addr(1'b0);
		rd(1);
		chk("idle status", d, 48'h40);
		t_meas();
		t_mode();
		t_cfg();
		give_verdict();
	end
endmodule // ptr_readout_tb_top
